// ===== cmd_accept_map.vh
// register offsets, field positions, reset values and timing counts
// assumes a 125 MHz core clock and a 32-bit classic Wishbone slave
`ifndef CMD_ACCEPT_MAP_VH
`define CMD_ACCEPT_MAP_VH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_NS          8
`define BUSY_MAX_NS     400
`define BUSY_MAX_CYC    (`BUSY_MAX_NS / `CLK_NS)
`define REQ2_MAX_US     700
`define REQ2_MAX_CYC    (`REQ2_MAX_US * 1000 / `CLK_NS)
`define REQ3_MAX_MS     20
`define REQ3_MAX_CYC    (`REQ3_MAX_MS * 1000000 / `CLK_NS)
`define CNT_W           22

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define ADR_W           8
`define OFS_FEATURE     8'h00
`define OFS_SECCNT      8'h04
`define OFS_SECNUM      8'h08
`define OFS_CYL_LO      8'h0C
`define OFS_CYL_HI      8'h10
`define OFS_DRVHEAD     8'h14
`define OFS_COMMAND     8'h18
`define OFS_STATUS      8'h1C
`define OFS_ALTSTAT     8'h20
`define OFS_DEVCTRL     8'h24
`define OFS_ERROR       8'h28
`define OFS_CMDINFO     8'h2C
`define OFS_FWCTRL      8'h30
`define OFS_EVTSTAT     8'h34
`define OFS_EVTMASK     8'h38
`define NUM_PARAM       5
`define IDX_SECCNT      1

// ---------------------------------------------------------------
// fields
// ---------------------------------------------------------------
`define HEAD_LBA_BIT    6
`define HEAD_DRIVE_BIT  4
`define HEAD_ONES       8'hA0
`define DC_NIEN_BIT     1
`define DC_SRST_BIT     2
`define ERR_ABRT        8'h04
`define FW_DONE_BIT     0
`define FW_ERR_BIT      1
`define FW_BUFRDY_BIT   2
`define FW_PWR_LSB      4
`define PWR_IDLE        2'h0
`define COUNT_IDLE_VAL  8'hFF
`define COUNT_STBY_VAL  8'h00
`define EVT_W           4

// ---------------------------------------------------------------
// decode codes {ext48, head_full, pwr, nop, class[1:0]}
// ---------------------------------------------------------------
`define CI_NONE         6'h00
`define CI_C1D          6'h01
`define CI_C1F          6'h11
`define CI_C1X          6'h21
`define CI_PWR          6'h09
`define CI_NOPD         6'h05
`define CI_NOPF         6'h15
`define CI_C2D          6'h02
`define CI_C2F          6'h12
`define CI_C2X          6'h22
`define CI_C3F          6'h13
`define CI_C3X          6'h23

`endif

// ===== cmd_accept.v
// command acceptance front end of a storage task-file interface
// assumes one 125 MHz clock, synchronous reset and a classic
// Wishbone master shared by host port and local firmware
//
// Added by the designer: register access over Wishbone and the register addresses.
`include "cmd_accept_map.vh"

// Overview of operation
// - class 1 raises busy within 400ns
// - class 2: busy, data request by 700us
// - class 3: busy, data request by 20ms
// - legacy opcodes complete with no operation
// - decode 40h and 42h verify read
// - decode CDh class 3, 38h write
// - full drive/head used where marked valid
// - drive-only commands ignore head bits
// - power query from E5h or 98h
// - standby power query returns count 00h
// - idle power query returns count FFh
// - status read clears pending, alternate not
// - other status bits hidden while busy
// - host interrupt only when disable bit zero
module cmd_accept #(
  parameter [`CNT_W-1:0] REQ2_MAX_CYC = `REQ2_MAX_CYC,
  parameter [`CNT_W-1:0] REQ3_MAX_CYC = `REQ3_MAX_CYC
) (
  input  wire              clk_i,
  input  wire              rst_i,
  input  wire [`ADR_W-1:0] adr_i,
  input  wire [31:0]       dat_i,
  input  wire [3:0]        sel_i,
  input  wire              we_i,
  input  wire              cyc_i,
  input  wire              stb_i,
  output reg  [31:0]       dat_o,
  output reg               ack_o,
  output reg               irq_o,
  output reg               host_irq_line_n_o,
  output reg               busy_flag_o,
  output reg               data_request_flag_o
);

  // -------------------------------------------------------------
  // states
  // -------------------------------------------------------------
  localparam [4:0] S_IDLE  = 5'h01;
  localparam [4:0] S_DEC   = 5'h02;
  localparam [4:0] S_EXEC  = 5'h04;
  localparam [4:0] S_SETUP = 5'h08;
  localparam [4:0] S_DATA  = 5'h10;

  // -------------------------------------------------------------
  // opcode decoder
  // -------------------------------------------------------------
  function [5:0] decode;
    input [7:0] op;
    begin
      casez (op)
        8'hE5, 8'h98: decode = `CI_PWR;
        8'h00, 8'hDE, 8'hDF,
        8'h1?: decode = `CI_NOPD;
        8'h7?, 8'h91: decode = `CI_NOPF;
        8'h40: decode = `CI_C1F;
        8'h42: decode = `CI_C1X;
        8'hC0, 8'hC8, 8'hC4, 8'h20, 8'h21,
        8'h87: decode = `CI_C1F;
        8'h25, 8'h29, 8'h24: decode = `CI_C1X;
        8'h90, 8'hE7, 8'hEA, 8'hEC, 8'hE3, 8'h97,
        8'hE1, 8'h95, 8'hE4, 8'h03, 8'hF1, 8'hF2,
        8'hF3, 8'hF4, 8'hF5, 8'hF6, 8'hEF, 8'hC6,
        8'hE6, 8'h99, 8'hB0, 8'hE2, 8'h96, 8'hE0,
        8'h94: decode = `CI_C1D;
        8'h38, 8'h50, 8'hCA, 8'h30,
        8'h31: decode = `CI_C2F;
        8'h06, 8'h35, 8'h34: decode = `CI_C2X;
        8'hE8: decode = `CI_C2D;
        8'hCD, 8'hC5: decode = `CI_C3F;
        8'h39: decode = `CI_C3X;
        default: decode = `CI_NONE;
      endcase
    end
  endfunction

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  reg  [4:0]        st_q;
  reg  [7:0]        cmd_q;
  reg  [5:0]        info_q;
  reg  [7:0]        drive_head_q;
  reg  [7:0]        err_reg_q;
  reg               err_q;
  reg               rdy_q;
  reg               nien_q;
  reg               srst_q;
  reg               pend_q;
  reg  [1:0]        pwr_q;
  reg  [`CNT_W-1:0] cnt_q;
  reg  [`EVT_W-1:0] evt_q;
  reg  [`EVT_W-1:0] mask_q;
  reg  [7:0]        cur_q [0:`NUM_PARAM-1];
  reg  [7:0]        prev_q [0:`NUM_PARAM-1];
  reg               pend_set;
  reg  [`EVT_W-1:0] evt_set;

  // -------------------------------------------------------------
  // bus decode
  // -------------------------------------------------------------
  wire              acc = cyc_i & stb_i & ~ack_o;
  wire              wr = acc & we_i;
  wire              rd = acc & ~we_i;
  wire [7:0]        ofs = {adr_i[7:2], 2'b00};
  wire              wr_b0 = wr & sel_i[0];
  wire              busy = busy_flag_o;
  wire [5:0]        info = decode(cmd_q);
  wire [1:0]        cls = info_q[1:0];
  wire              fw_wr = wr_b0 & (ofs == `OFS_FWCTRL);
  wire              fw_done = fw_wr & dat_i[`FW_DONE_BIT];
  wire              fw_err = dat_i[`FW_ERR_BIT];
  wire              fw_bufrdy = fw_wr & dat_i[`FW_BUFRDY_BIT];
  // task file and opcode writes refused while busy
  wire              tf_wr = wr_b0 & ~busy & ~srst_q;
  wire              cmd_wr = tf_wr & (ofs == `OFS_COMMAND)
                             & st_q[0];
  wire              stat_rd = rd & (ofs == `OFS_STATUS);
  wire              evt_rd = rd & (ofs == `OFS_EVTSTAT);
  wire              count_load = st_q[1] & info[3];
  // standby or its transitions return zero
  wire [7:0]        count_val = (pwr_q == `PWR_IDLE) ?
                                `COUNT_IDLE_VAL : `COUNT_STBY_VAL;
  wire [`CNT_W-1:0] req_max = (cls == 2'd3) ?
                              REQ3_MAX_CYC : REQ2_MAX_CYC;

  // -------------------------------------------------------------
  // parameter registers
  // -------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_PARAM; gi = gi + 1) begin : g_param
      // each task-file write shifts current into previous; the power query count load does not
      always @(posedge clk_i) begin
        if (rst_i | srst_q) begin
          cur_q[gi]  <= 8'h00;
          prev_q[gi] <= 8'h00;
        end else if (gi == `IDX_SECCNT && count_load) begin
          cur_q[gi] <= count_val;
        end else if (tf_wr && ofs == 4 * gi) begin
          prev_q[gi] <= cur_q[gi];
          cur_q[gi]  <= dat_i[7:0];
        end
      end
    end
  endgenerate

  // -------------------------------------------------------------
  // argument view for firmware
  // -------------------------------------------------------------
  // head bits pass only where drive/head is valid
  wire [3:0]  head_eff = info_q[4] ? drive_head_q[3:0] : 4'h0;
  wire        drive_select_bit = drive_head_q[`HEAD_DRIVE_BIT];
  wire [15:0] cmdinfo = {cmd_q, head_eff, drive_select_bit,
                         drive_head_q[`HEAD_LBA_BIT], info_q[5:4]};

  // only busy is shown while busy
  wire [7:0]  stat = busy ? 8'h80 :
                     {1'b0, rdy_q, 1'b0, rdy_q,
                      data_request_flag_o, 2'b00, err_q};

  // -------------------------------------------------------------
  // control registers
  // -------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      drive_head_q <= `HEAD_ONES;
      nien_q <= 1'b0;
      srst_q <= 1'b0;
      pwr_q  <= `PWR_IDLE;
      mask_q <= {`EVT_W{1'b0}};
      rdy_q  <= 1'b0;
    end else begin
      rdy_q <= ~srst_q;
      if (tf_wr && ofs == `OFS_DRVHEAD)
        drive_head_q <= dat_i[7:0] | `HEAD_ONES;
      // control is writable even while busy
      if (wr_b0 && ofs == `OFS_DEVCTRL) begin
        nien_q <= dat_i[`DC_NIEN_BIT];
        srst_q <= dat_i[`DC_SRST_BIT];
      end
      if (fw_wr)
        pwr_q <= dat_i[`FW_PWR_LSB+1:`FW_PWR_LSB];
      if (wr_b0 && ofs == `OFS_EVTMASK)
        mask_q <= dat_i[`EVT_W-1:0];
    end
  end

  // -------------------------------------------------------------
  // acceptance sequencer
  // -------------------------------------------------------------
  // events: 0 accepted, 1 data request set, 2 complete, 3 aborted
  always @(posedge clk_i) begin
    pend_set <= 1'b0;
    evt_set  <= {`EVT_W{1'b0}};
    if (rst_i | srst_q) begin
      st_q                <= S_IDLE;
      cmd_q               <= 8'h00;
      info_q              <= `CI_NONE;
      err_q               <= 1'b0;
      err_reg_q           <= 8'h00;
      cnt_q               <= {`CNT_W{1'b0}};
      busy_flag_o         <= rst_i ? 1'b0 : 1'b1;
      data_request_flag_o <= 1'b0;
    end else begin
      case (st_q)
        S_IDLE: begin
          // busy rises one cycle after the opcode
          busy_flag_o <= cmd_wr;
          if (cmd_wr) begin
            cmd_q <= dat_i[7:0];
            // new opcode clears data request and error
            data_request_flag_o <= 1'b0;
            err_q               <= 1'b0;
            err_reg_q           <= 8'h00;
            evt_set[0]          <= 1'b1;
            st_q                <= S_DEC;
          end
        end
        S_DEC: begin
          info_q <= info;
          cnt_q  <= {`CNT_W{1'b0}};
          if (info[1:0] == 2'd0) begin
            err_q       <= 1'b1;
            err_reg_q   <= `ERR_ABRT;
            busy_flag_o <= 1'b0;
            pend_set    <= 1'b1;
            evt_set[3]  <= 1'b1;
            st_q        <= S_IDLE;
          end else if (info[3] | info[2]) begin
            // completes at once, no media work
            busy_flag_o <= 1'b0;
            pend_set    <= 1'b1;
            evt_set[2]  <= 1'b1;
            st_q        <= S_IDLE;
          end else if (info[1:0] == 2'd1) begin
            st_q <= S_EXEC;
          end else begin
            st_q <= S_SETUP;
          end
        end
        S_EXEC: begin
          if (fw_done) begin
            busy_flag_o <= 1'b0;
            err_q       <= fw_err;
            err_reg_q   <= fw_err ? `ERR_ABRT : 8'h00;
            pend_set    <= 1'b1;
            evt_set[2]  <= ~fw_err;
            evt_set[3]  <= fw_err;
            st_q        <= S_IDLE;
          end
        end
        S_SETUP: begin
          cnt_q <= cnt_q + 1'b1;
          // data request forced by the class 2 deadline
          // data request forced by the class 3 deadline
          if (fw_bufrdy || cnt_q >= req_max - 2'd2) begin
            data_request_flag_o <= 1'b1;
            pend_set            <= 1'b1;
            evt_set[1]          <= 1'b1;
            st_q                <= S_DATA;
          end
        end
        S_DATA: begin
          // busy drops one cycle after data request
          busy_flag_o <= 1'b0;
          if (fw_done) begin
            data_request_flag_o <= 1'b0;
            err_q               <= fw_err;
            err_reg_q   <= fw_err ? `ERR_ABRT : 8'h00;
            pend_set            <= 1'b1;
            evt_set[2]          <= ~fw_err;
            evt_set[3]          <= fw_err;
            st_q                <= S_IDLE;
          end
        end
        default: begin
          st_q        <= S_IDLE;
          busy_flag_o <= 1'b0;
        end
      endcase
    end
  end

  // -------------------------------------------------------------
  // interrupts
  // -------------------------------------------------------------
  // set wins over a clearing read in the same cycle
  wire              pend_d = pend_set | (pend_q & ~stat_rd);
  wire [`EVT_W-1:0] evt_d = evt_set
                            | (evt_q & {`EVT_W{~evt_rd}});

  always @(posedge clk_i) begin
    if (rst_i | srst_q) begin
      pend_q            <= 1'b0;
      evt_q             <= {`EVT_W{1'b0}};
      irq_o             <= 1'b0;
      host_irq_line_n_o <= 1'b1;
    end else begin
      pend_q <= pend_d;
      evt_q  <= evt_d;
      irq_o  <= |(evt_d & mask_q);
      // gated by the active high disable bit
      host_irq_line_n_o <= ~(pend_d & ~nien_q);
    end
  end

  // -------------------------------------------------------------
  // wishbone read and ack
  // -------------------------------------------------------------
  // one wait state: ack one cycle after the strobe, data with it
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= acc;
      if (rd) begin
        case (ofs)
          `OFS_FEATURE, `OFS_SECCNT, `OFS_SECNUM,
          `OFS_CYL_LO, `OFS_CYL_HI:
            dat_o <= {16'h0000, prev_q[adr_i[4:2]],
                      cur_q[adr_i[4:2]]};
          `OFS_DRVHEAD: dat_o <= {24'h000000, drive_head_q};
          `OFS_STATUS,
          `OFS_ALTSTAT: dat_o <= {24'h000000, stat};
          `OFS_DEVCTRL: dat_o <= {29'h0000000, srst_q,
                                  nien_q, 1'b0};
          `OFS_ERROR:   dat_o <= {24'h000000, err_reg_q};
          `OFS_CMDINFO: dat_o <= {16'h0000, cmdinfo};
          `OFS_FWCTRL:  dat_o <= {26'h000000, pwr_q, 4'h0};
          `OFS_EVTSTAT: dat_o <= {28'h0000000, evt_q};
          `OFS_EVTMASK: dat_o <= {28'h0000000, mask_q};
          default:      dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// ===== cmd_accept_assertions.sv
// port-level checks for the command acceptance block
// assumes one clock domain and the offsets of cmd_accept_map.vh
`include "cmd_accept_map.vh"
module cmd_accept_checker #(
  parameter [`CNT_W-1:0] REQ2_MAX_CYC = `REQ2_MAX_CYC,
  parameter [`CNT_W-1:0] REQ3_MAX_CYC = `REQ3_MAX_CYC
) (
  input wire              clk_i,
  input wire              rst_i,
  input wire [`ADR_W-1:0] adr_i,
  input wire [31:0]       dat_i,
  input wire [3:0]        sel_i,
  input wire              we_i,
  input wire              cyc_i,
  input wire              stb_i,
  input wire [31:0]       dat_o,
  input wire              ack_o,
  input wire              irq_o,
  input wire              host_irq_line_n_o,
  input wire              busy_flag_o,
  input wire              data_request_flag_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // decoded bus requests
  // ----------------------------------------
  wire taken   = cyc_i & stb_i & ~ack_o;
  wire cmd_wr  = taken & we_i & sel_i[0] & ({adr_i[7:2], 2'b00} == `OFS_COMMAND);
  wire stat_rd = taken & ~we_i & ({adr_i[7:2], 2'b00} == `OFS_STATUS);
  wire alt_rd  = taken & ~we_i & ({adr_i[7:2], 2'b00} == `OFS_ALTSTAT);
  wire idle    = ~busy_flag_o & ~data_request_flag_o;
  logic nien_q;
  // shadow of the interrupt disable bit, so the line can be judged
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nien_q <= 1'b0;
    end else if (taken & we_i & sel_i[0] & ({adr_i[7:2], 2'b00} == `OFS_DEVCTRL)) begin
      nien_q <= dat_i[`DC_NIEN_BIT];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (taken |=> ack_o ##1 !ack_o)
    else $error("ack is not one pulse after a request");
  busy_rise_a: assert property (cmd_wr && idle |=> busy_flag_o)
    else $error("busy did not rise after an opcode");
  req_clear_a: assert property (cmd_wr && idle |=> !data_request_flag_o [*2])
    else $error("data request stands after an opcode");
  busy_drop_a: assert property ($rose(data_request_flag_o) |=> !busy_flag_o)
    else $error("busy still high after data request");
  req_inbusy_a: assert property ($rose(data_request_flag_o) |-> $past(busy_flag_o))
    else $error("data request rose outside a command");
  status_clr_a: assert property (stat_rd && idle |-> ##2 host_irq_line_n_o)
    else $error("status read left the host interrupt pending");
  alt_keep_a: assert property (alt_rd && idle && !host_irq_line_n_o |-> ##2 !host_irq_line_n_o)
    else $error("alternate status read cleared the host interrupt");
  irq_off_a: assert property (nien_q && $past(nien_q) |-> host_irq_line_n_o)
    else $error("host interrupt asserted while disabled");
  busy_hide_a: assert property (stat_rd && busy_flag_o |=> dat_o[7:0] == 8'h80)
    else $error("status shows more than busy while busy");
  cmd_seen_c: cover property (cmd_wr && idle);
  req_seen_c: cover property ($rose(data_request_flag_o));
  irq_seen_c: cover property ($fell(host_irq_line_n_o));
endmodule

// ===== host_model.sv
// host controller model: classic single-cycle bus master on the task file
// assumes the testbench calls its tasks from one process only
module host_model (
  input  wire         clk_i,
  input  wire         ack_i,
  input  wire  [31:0] dat_i,
  input  wire         busy_i,
  output logic [7:0]  adr_o,
  output logic [31:0] dat_o,
  output logic [3:0]  sel_o,
  output logic        we_o,
  output logic        cyc_o,
  output logic        stb_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {adr_o, dat_o, sel_o, we_o, cyc_o, stb_o} = '0;
  end
  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  // request held until ack is sampled; released lines show the inverse
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, sel_o} <= {2'b11, w, 4'h1};
    adr_o <= a;
    dat_o <= {24'h000000, d};
    @(posedge clk_i);
    while (ack_i !== 1'b1) @(posedge clk_i);
    q = dat_i;
    {cyc_o, stb_o, we_o} <= 3'h0;
    adr_o <= ~a;
    dat_o <= ~{24'h000000, d};
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 8'h00, q);
  endtask
  task automatic wait_idle();
    @(posedge clk_i);
    while (busy_i !== 1'b0) @(posedge clk_i);
  endtask
  task automatic cmd(input logic [7:0] op);
    wait_idle();
    wr(8'h18, op);
  endtask
endmodule

// ===== ata_command_acceptance_tb_top.sv
// testbench for the command acceptance block, host model as bus master
// assumes a 125 MHz clock and shortened data request bounds
`include "cmd_accept_map.vh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module ata_command_acceptance_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam [`CNT_W-1:0] REQ2_MAX_CYC = 22'h14;
  localparam [`CNT_W-1:0] REQ3_MAX_CYC = 22'h28;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [3:0] sel;
  logic we, cyc, stb, ack, irq, irq_n, busy, data_req;
  logic [1:0] pwr = 2'h0;
  int n_errors = 0, checks = 0, cycles = 0, n;
  logic [7:0] nops [6] = '{8'h00, 8'h10, 8'h7A, 8'h91, 8'hDE, 8'hDF};
  logic [7:0] wops [6] = '{8'h30, 8'h38, 8'hCD, 8'hC5, 8'h35, 8'h39};
  int lims [6] = '{REQ2_MAX_CYC, REQ2_MAX_CYC, REQ3_MAX_CYC, REQ3_MAX_CYC,
                   REQ2_MAX_CYC, REQ3_MAX_CYC};
  always #4 clk_i = ~clk_i;
  cmd_accept #(.REQ2_MAX_CYC(REQ2_MAX_CYC), .REQ3_MAX_CYC(REQ3_MAX_CYC)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat), .sel_i(sel), .we_i(we),
    .cyc_i(cyc), .stb_i(stb), .dat_o(rdat), .ack_o(ack), .irq_o(irq),
    .host_irq_line_n_o(irq_n), .busy_flag_o(busy), .data_request_flag_o(data_req));
  host_model host (
    .clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .busy_i(busy), .adr_o(adr), .dat_o(wdat),
    .sel_o(sel), .we_o(we), .cyc_o(cyc), .stb_o(stb));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [15:0] e, input string nm);
    host.rd(a, q);
    `CHK(nm, e, q[15:0])
  endtask
  // firmware keeps the power mode in every control write
  task automatic fw(input logic [3:0] b);
    host.wr(`OFS_FWCTRL, {2'b00, pwr, b});
  endtask
  // completion plus the one-cycle lag of the interrupt lines
  task automatic settle();
    host.wait_idle();
    repeat (2) @(posedge clk_i);
  endtask
  // a hang ends the run as a mismatch
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    host.wr(`OFS_SECCNT, 8'h12);
    host.wr(`OFS_SECCNT, 8'h34);
    rdchk(`OFS_SECCNT, 16'h1234, "sector count pair");
    rdchk(8'hFC, 16'h0000, "unmapped read");
    host.wr(`OFS_DRVHEAD, 8'h5F);
    rdchk(`OFS_DRVHEAD, 16'h00FF, "drive head");
    $display("test parameters done");
    for (int i = 0; i < 2; i++) begin
      host.cmd(i ? 8'h42 : 8'h40);
      `CHK("busy after opcode", 1'b1, busy)
      rdchk(`OFS_STATUS, 16'h0080, "status while busy");
      host.wr(`OFS_SECCNT, 8'h99);
      rdchk(`OFS_CMDINFO, i ? 16'h420E : 16'h40FD, "command info");
      fw(i ? 4'h3 : 4'h1);
      settle();
      rdchk(`OFS_SECCNT, 16'h1234, "count kept while busy");
      rdchk(`OFS_ERROR, i ? 16'h0004 : 16'h0000, "verify error code");
      rdchk(`OFS_STATUS, i ? 16'h0051 : 16'h0050, "verify status");
    end
    $display("test verify commands done");
    foreach (nops[i]) begin
      host.cmd(nops[i]);
      settle();
      `CHK("no-op interrupt", 1'b0, irq_n)
      rdchk(`OFS_ALTSTAT, 16'h0050, "alternate status");
      `CHK("alternate keeps interrupt", 1'b0, irq_n)
      rdchk(`OFS_STATUS, 16'h0050, "no-op status");
      @(posedge clk_i);
      `CHK("status read clears", 1'b1, irq_n)
    end
    $display("test no-op commands done");
    for (int m = 0; m < 4; m++) begin
      pwr = m[1:0];
      fw(4'h0);
      host.cmd(m[0] ? 8'h98 : 8'hE5);
      settle();
      `CHK("power query interrupt", 1'b0, irq_n)
      host.rd(`OFS_SECCNT, q);
      `CHK("power mode count", (m == 0) ? 8'hFF : 8'h00, q[7:0])
      rdchk(`OFS_STATUS, 16'h0050, "power query status");
    end
    pwr = 2'h0;
    fw(4'h0);
    $display("test power query done");
    host.rd(`OFS_EVTSTAT, q);
    `CHK("firmware error event", 1'b1, q[3])
    host.wr(`OFS_EVTMASK, 8'h08);
    host.cmd(8'hFF);
    settle();
    `CHK("abort event irq", 1'b1, irq)
    rdchk(`OFS_STATUS, 16'h0051, "abort status");
    rdchk(`OFS_ERROR, 16'h0004, "abort code");
    host.rd(`OFS_EVTSTAT, q);
    `CHK("abort event bit", 1'b1, q[3])
    @(posedge clk_i);
    `CHK("event read clears irq", 1'b0, irq)
    host.wr(`OFS_EVTMASK, 8'h00);
    host.cmd(8'hFF);
    settle();
    `CHK("masked event irq", 1'b0, irq)
    host.cmd(8'h00);
    settle();
    rdchk(`OFS_STATUS, 16'h0050, "error cleared");
    rdchk(`OFS_ERROR, 16'h0000, "error code cleared");
    $display("test abort done");
    foreach (wops[i]) begin
      host.cmd(wops[i]);
      `CHK("busy on write command", 1'b1, busy)
      if (wops[i] == 8'hCD) fw(4'h4);
      n = 0;
      while (data_req !== 1'b1 && n < 100) begin
        @(posedge clk_i);
        n++;
      end
      `CHK("data request in time", 1'b1, n <= lims[i])
      repeat (2) @(posedge clk_i);
      `CHK("busy dropped", 1'b0, busy)
      rdchk(`OFS_STATUS, 16'h0058, "data request status");
      fw(4'h1);
      settle();
      `CHK("data request done", 1'b0, data_req)
      rdchk(`OFS_STATUS, 16'h0050, "write done status");
    end
    $display("test write commands done");
    host.wr(`OFS_DEVCTRL, 8'h02);
    host.cmd(8'h00);
    settle();
    `CHK("disabled interrupt", 1'b1, irq_n)
    host.wr(`OFS_DEVCTRL, 8'h00);
    repeat (2) @(posedge clk_i);
    `CHK("enabled interrupt", 1'b0, irq_n)
    rdchk(`OFS_STATUS, 16'h0050, "final status");
    $display("test interrupt disable done");
    // soft reset holds busy and wipes the parameter registers
    host.wr(`OFS_DEVCTRL, 8'h04);
    repeat (2) @(posedge clk_i);
    `CHK("busy in soft reset", 1'b1, busy)
    rdchk(`OFS_STATUS, 16'h0080, "status in soft reset");
    host.wr(`OFS_DEVCTRL, 8'h00);
    settle();
    rdchk(`OFS_SECCNT, 16'h0000, "soft reset clears count");
    rdchk(`OFS_STATUS, 16'h0050, "status after soft reset");
    $display("test soft reset done");
    report_and_stop();
  end
endmodule
bind cmd_accept cmd_accept_checker #(.REQ2_MAX_CYC(REQ2_MAX_CYC), .REQ3_MAX_CYC(REQ3_MAX_CYC)) chk (
  .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
  .host_irq_line_n_o(host_irq_line_n_o), .busy_flag_o(busy_flag_o),
  .data_request_flag_o(data_request_flag_o));
